/* File: rtl/spl_cfg.svh */
// constants for the sector protection and lockdown command block
// Overview of operation
// - program map: 3D 2A 7F FC then eight data bytes, sectors 0 to 7
// - map program starts on chip select rise; busy until it completes
// - ninth and later data bytes wrap to byte location 0 and onward
// - map reprogram accepted whether global protection is on or off
// - map program writes its data into buffer 1, overwriting it
// - read map: 32h plus three dummies, then bytes 0..7 shift out
// - after eighth read byte, further clocks shift out 00h
// - chip select rise ends a map read and floats serial output
// - lock sector: 3D 2A 7F 30 then three address bytes
// - lockdown starts on chip select rise after address; busy meanwhile
// - locked sectors reject every erase and program until reset
// - read lock map: 35h plus three dummies, then eight bytes out
// - lock map bytes FFh/00h; sector 0 uses bits 7:6 and 5:4
// - freeze: 34 55 AA 40; further bytes in that frame ignored
// - freeze starts on chip select rise; lock state frozen and lock enable flag cleared when it ends
// - once frozen, every sector lockdown command is ignored
// - map sector 0: bits 7:6 sub 0a, 5:4 sub 0b, 11 protects
// - map byte all ones protects its sector, all zeros unprotects
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

`define SPL_OP_PFX0      8'h3d
`define SPL_OP_PFX1      8'h2a
`define SPL_OP_PFX2      8'h7f
`define SPL_OP_PROG      8'hfc
`define SPL_OP_LOCK      8'h30
`define SPL_OP_RD_PROT   8'h32
`define SPL_OP_RD_LOCK   8'h35
`define SPL_OP_FRZ0      8'h34
`define SPL_OP_FRZ1      8'h55
`define SPL_OP_FRZ2      8'haa
`define SPL_OP_FRZ3      8'h40

`define SPL_MAP_BYTES    8
`define SPL_PROT_RESET   8'h00
`define SPL_LOCK_RESET   8'h00
`define SPL_BYTE_ALL     8'hff
`define SPL_SUB0A_MASK   8'hc0
`define SPL_SUB0B_MASK   8'h30
`define SPL_SUB0A_HI     7
`define SPL_SUB0B_HI     5
`define SPL_SECT_HI      18
`define SPL_SECT_LO      16
`define SPL_PAGE_HI      18
`define SPL_PAGE_LO      8
`define SPL_SUB0A_PAGES  8
`define SPL_DUMMY_BYTES  3
`define SPL_ADDR_BYTES   3

`define SPL_CLK_MHZ      125
`define SPL_PROG_TIME_US 200
`define SPL_FRZ_TIME_US  200

`endif

/* File: rtl/spl_pkg.sv */
// types for the sector protection and lockdown command block
`default_nettype none
package spl_pkg;
   typedef enum logic [3:0] {
      SPL_ST_OP, SPL_ST_PFX, SPL_ST_FRZ, SPL_ST_PROG, SPL_ST_ADDR,
      SPL_ST_LOCK_OK, SPL_ST_FRZ_OK, SPL_ST_DUMMY, SPL_ST_OUT, SPL_ST_IGN
   } spl_state_t;
   typedef enum logic [1:0] {
      SPL_NV_NONE, SPL_NV_PROG, SPL_NV_LOCK, SPL_NV_FRZ
   } spl_nvop_t;
endpackage
`default_nettype wire

/* File: rtl/spl_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none
module spl_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // pins in, synchronised levels out
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q_out  <= RST_VAL;
      end else begin
         meta_r <= meta_nxt;
         q_out  <= q_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/spl_core.sv */
// sector protection map and lockdown command handling behind the spi pins
`include "spl_cfg.svh"
`default_nettype none
module spl_core #(
   parameter int unsigned PROG_CYC = `SPL_PROG_TIME_US * `SPL_CLK_MHZ,
   parameter int unsigned FRZ_CYC  = `SPL_FRZ_TIME_US * `SPL_CLK_MHZ
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // spi pins
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        si,
   output logic             so,
   output logic             so_oe,
   // status
   output logic             busy_r,
   output logic             lock_cmd_enabled_flag_r,
   // buffer 1 write port
   output logic             buf1_we_r,
   output logic [2:0]       buf1_idx_r,
   output logic [7:0]       buf1_data_r,
   // erase and program permission query from the array
   input  wire logic        pe_req,
   input  wire logic [18:0] pe_addr,
   input  wire logic        prot_en,
   output logic             pe_ack_r,
   output logic             pe_allow_r
);
   localparam int unsigned NB = `SPL_MAP_BYTES;

   generate
      if (PROG_CYC < 1 || FRZ_CYC < 1) begin : g_bad_time
         $error("spl_core: operation times must be at least one cycle");
      end
   endgenerate

   // protection or lock state of the byte that covers an address
   function automatic logic map_hit(input logic [7:0] b,
                                    input logic [18:0] a);
      logic [2:0]  sec;
      logic [10:0] pg;
      sec = a[`SPL_SECT_HI:`SPL_SECT_LO];
      pg  = a[`SPL_PAGE_HI:`SPL_PAGE_LO];
      if (sec != 3'h0)
         map_hit = &b;
      else if (pg < 11'(`SPL_SUB0A_PAGES))
         map_hit = &b[`SPL_SUB0A_HI -: 2];
      else
         map_hit = &b[`SPL_SUB0B_HI -: 2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin sampling
   logic [2:0] pin_s;
   logic       sck_d_r;
   logic       cs_d_r;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;
   logic       cs_low;

   spl_sync #(.W(3), .RST_VAL(3'b010)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .d_in     ({sck, cs_n, si}),
      .q_out    (pin_s)
   );

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sck_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
      end else begin
         sck_d_r <= pin_s[2];
         cs_d_r  <= pin_s[1];
      end
   end

   assign cs_low   = ~pin_s[1];
   assign sck_rise = cs_low & pin_s[2] & ~sck_d_r;
   assign sck_fall = cs_low & ~pin_s[2] & sck_d_r;
   assign cs_rise  = pin_s[1] & ~cs_d_r;

   ////////////////////////////////////////////////////////////////////////
   // nonvolatile maps, working buffer and self-timed operations
   logic [7:0]        prot_r  [NB];
   logic [7:0]        prot_nxt[NB];
   logic [7:0]        lock_r  [NB];
   logic [7:0]        lock_nxt[NB];
   logic [7:0]        stage_r  [NB];
   logic [7:0]        stage_nxt[NB];
   logic              frozen_r;
   logic              frozen_nxt;
   spl_pkg::spl_nvop_t nvop_r;
   spl_pkg::spl_nvop_t nvop_nxt;
   logic [31:0]       timer_r;
   logic [31:0]       timer_nxt;
   logic [23:0]       addr_r;
   logic [23:0]       addr_nxt;

   ////////////////////////////////////////////////////////////////////////
   // serial command decode
   spl_pkg::spl_state_t st_r;
   spl_pkg::spl_state_t st_nxt;
   logic [2:0]  bit_r;
   logic [2:0]  bit_nxt;
   logic [7:0]  sh_r;
   logic [7:0]  sh_nxt;
   logic [3:0]  idx_r;
   logic [3:0]  idx_nxt;
   logic [2:0]  wptr_r;
   logic [2:0]  wptr_nxt;
   logic        rd_lock_r;
   logic        rd_lock_nxt;
   logic [3:0]  obyte_r;
   logic [3:0]  obyte_nxt;
   logic [2:0]  obit_r;
   logic [2:0]  obit_nxt;
   logic        so_nxt;
   logic        so_oe_nxt;
   logic        we_nxt;
   logic [2:0]  widx_nxt;
   logic [7:0]  wdat_nxt;
   logic [7:0]  byte_in;
   logic        byte_done;
   logic [7:0]  obyte_val;

   assign byte_in   = {sh_r[6:0], pin_s[0]};
   assign byte_done = sck_rise && (bit_r == 3'h7);

   always_comb begin
      st_nxt      = st_r;
      bit_nxt     = bit_r;
      sh_nxt      = sh_r;
      idx_nxt     = idx_r;
      wptr_nxt    = wptr_r;
      rd_lock_nxt = rd_lock_r;
      obyte_nxt   = obyte_r;
      obit_nxt    = obit_r;
      so_nxt      = so;
      we_nxt      = 1'b0;
      widx_nxt    = buf1_idx_r;
      wdat_nxt    = buf1_data_r;
      addr_nxt    = addr_r;
      obyte_val   = 8'h00;
      for (int i = 0; i < NB; i++) begin
         stage_nxt[i] = stage_r[i];
      end
      if (obyte_r < 4'(NB))
         obyte_val = rd_lock_r ? lock_r[obyte_r[2:0]]
                               : prot_r[obyte_r[2:0]];
      if (!cs_low) begin
         st_nxt   = spl_pkg::SPL_ST_OP;
         bit_nxt  = 3'h0;
         idx_nxt  = 4'h0;
         obit_nxt = 3'h0;
      end else begin
         if (sck_rise) begin
            sh_nxt  = byte_in;
            bit_nxt = bit_r + 3'h1;
         end
         if (byte_done) begin
            if (idx_r != 4'hf)
               idx_nxt = idx_r + 4'h1;
            case (st_r)
               spl_pkg::SPL_ST_OP: begin
                  if (busy_r)
                     st_nxt = spl_pkg::SPL_ST_IGN;
                  else if (byte_in == `SPL_OP_PFX0)
                     st_nxt = spl_pkg::SPL_ST_PFX;
                  else if (byte_in == `SPL_OP_FRZ0)
                     st_nxt = spl_pkg::SPL_ST_FRZ;
                  else if (byte_in == `SPL_OP_RD_PROT ||
                           byte_in == `SPL_OP_RD_LOCK) begin
                     st_nxt      = spl_pkg::SPL_ST_DUMMY;
                     rd_lock_nxt = (byte_in == `SPL_OP_RD_LOCK);
                  end else
                     st_nxt = spl_pkg::SPL_ST_IGN;
               end
               spl_pkg::SPL_ST_PFX: begin
                  st_nxt = spl_pkg::SPL_ST_IGN;
                  if (idx_r == 4'h1 && byte_in == `SPL_OP_PFX1)
                     st_nxt = spl_pkg::SPL_ST_PFX;
                  else if (idx_r == 4'h2 && byte_in == `SPL_OP_PFX2)
                     st_nxt = spl_pkg::SPL_ST_PFX;
                  else if (idx_r == 4'h3 && byte_in == `SPL_OP_PROG) begin
                     st_nxt   = spl_pkg::SPL_ST_PROG;
                     wptr_nxt = 3'h0;
                  end else if (idx_r == 4'h3 && byte_in == `SPL_OP_LOCK &&
                               !frozen_r)
                     st_nxt = spl_pkg::SPL_ST_ADDR;
               end
               spl_pkg::SPL_ST_FRZ: begin
                  st_nxt = spl_pkg::SPL_ST_IGN;
                  if ((idx_r == 4'h1 && byte_in == `SPL_OP_FRZ1) ||
                      (idx_r == 4'h2 && byte_in == `SPL_OP_FRZ2))
                     st_nxt = spl_pkg::SPL_ST_FRZ;
                  else if (idx_r == 4'h3 && byte_in == `SPL_OP_FRZ3)
                     st_nxt = spl_pkg::SPL_ST_FRZ_OK;
               end
               spl_pkg::SPL_ST_PROG: begin
                  stage_nxt[wptr_r] = byte_in;
                  we_nxt   = 1'b1;
                  widx_nxt = wptr_r;
                  wdat_nxt = byte_in;
                  wptr_nxt = wptr_r + 3'h1;
               end
               spl_pkg::SPL_ST_ADDR: begin
                  addr_nxt = {addr_r[15:0], byte_in};
                  if (idx_r == 4'(3 + `SPL_ADDR_BYTES))
                     st_nxt = spl_pkg::SPL_ST_LOCK_OK;
               end
               spl_pkg::SPL_ST_DUMMY: begin
                  if (idx_r == 4'(`SPL_DUMMY_BYTES)) begin
                     st_nxt    = spl_pkg::SPL_ST_OUT;
                     obyte_nxt = 4'h0;
                     obit_nxt  = 3'h0;
                  end
               end
               spl_pkg::SPL_ST_LOCK_OK,
               spl_pkg::SPL_ST_FRZ_OK,
               spl_pkg::SPL_ST_OUT,
               spl_pkg::SPL_ST_IGN: ;
               default: st_nxt = spl_pkg::SPL_ST_IGN;
            endcase
         end
         if (sck_fall && st_r == spl_pkg::SPL_ST_OUT) begin
            so_nxt   = obyte_val[3'h7 - obit_r];
            obit_nxt = obit_r + 3'h1;
            if (obit_r == 3'h7 && obyte_r != 4'(NB))
               obyte_nxt = obyte_r + 4'h1;
         end
      end
      so_oe_nxt = cs_low && (st_nxt == spl_pkg::SPL_ST_OUT);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r        <= spl_pkg::SPL_ST_OP;
         bit_r       <= 3'h0;
         sh_r        <= 8'h00;
         idx_r       <= 4'h0;
         wptr_r      <= 3'h0;
         rd_lock_r   <= 1'b0;
         obyte_r     <= 4'h0;
         obit_r      <= 3'h0;
         so          <= 1'b0;
         so_oe       <= 1'b0;
         buf1_we_r   <= 1'b0;
         buf1_idx_r  <= 3'h0;
         buf1_data_r <= 8'h00;
      end else begin
         st_r        <= st_nxt;
         bit_r       <= bit_nxt;
         sh_r        <= sh_nxt;
         idx_r       <= idx_nxt;
         wptr_r      <= wptr_nxt;
         rd_lock_r   <= rd_lock_nxt;
         obyte_r     <= obyte_nxt;
         obit_r      <= obit_nxt;
         so          <= so_nxt;
         so_oe       <= so_oe_nxt;
         buf1_we_r   <= we_nxt;
         buf1_idx_r  <= widx_nxt;
         buf1_data_r <= wdat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // self-timed program, lockdown and freeze
   logic [2:0] lsec;
   logic       lsub0a;
   logic       pe_ack_nxt;
   logic       pe_allow_nxt;

   assign lsec   = addr_r[`SPL_SECT_HI:`SPL_SECT_LO];
   assign lsub0a = addr_r[`SPL_PAGE_HI:`SPL_PAGE_LO] <
                   11'(`SPL_SUB0A_PAGES);

   always_comb begin
      nvop_nxt   = nvop_r;
      timer_nxt  = timer_r;
      frozen_nxt = frozen_r;
      for (int i = 0; i < NB; i++) begin
         prot_nxt[i] = prot_r[i];
         lock_nxt[i] = lock_r[i];
      end
      if (nvop_r == spl_pkg::SPL_NV_NONE) begin
         if (cs_rise) begin
            case (st_r)
               spl_pkg::SPL_ST_PROG: begin
                  nvop_nxt  = spl_pkg::SPL_NV_PROG;
                  timer_nxt = 32'(PROG_CYC - 1);
               end
               spl_pkg::SPL_ST_LOCK_OK: begin
                  nvop_nxt  = spl_pkg::SPL_NV_LOCK;
                  timer_nxt = 32'(PROG_CYC - 1);
               end
               spl_pkg::SPL_ST_FRZ_OK: begin
                  nvop_nxt  = spl_pkg::SPL_NV_FRZ;
                  timer_nxt = 32'(FRZ_CYC - 1);
               end
               default: nvop_nxt = spl_pkg::SPL_NV_NONE;
            endcase
         end
      end else if (timer_r != 32'h0) begin
         timer_nxt = timer_r - 32'h1;
      end else begin
         nvop_nxt = spl_pkg::SPL_NV_NONE;
         case (nvop_r)
            spl_pkg::SPL_NV_PROG: begin
               for (int i = 0; i < NB; i++) begin
                  prot_nxt[i] = stage_r[i];
               end
            end
            spl_pkg::SPL_NV_LOCK: begin
               if (lsec != 3'h0)
                  lock_nxt[lsec] = `SPL_BYTE_ALL;
               else if (lsub0a)
                  lock_nxt[0] = lock_r[0] | `SPL_SUB0A_MASK;
               else
                  lock_nxt[0] = lock_r[0] | `SPL_SUB0B_MASK;
            end
            spl_pkg::SPL_NV_FRZ: frozen_nxt = 1'b1;
            default: nvop_nxt = spl_pkg::SPL_NV_NONE;
         endcase
      end
      pe_ack_nxt   = pe_req;
      pe_allow_nxt = !map_hit(lock_r[pe_addr[`SPL_SECT_HI:`SPL_SECT_LO]],
                              pe_addr) &&
                     !(prot_en &&
                       map_hit(prot_r[pe_addr[`SPL_SECT_HI:`SPL_SECT_LO]],
                               pe_addr));
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NB; i++) begin
            prot_r[i]  <= `SPL_PROT_RESET;
            lock_r[i]  <= `SPL_LOCK_RESET;
            stage_r[i] <= `SPL_PROT_RESET;
         end
         frozen_r                <= 1'b0;
         nvop_r                  <= spl_pkg::SPL_NV_NONE;
         timer_r                 <= 32'h0;
         addr_r                  <= 24'h0;
         busy_r                  <= 1'b0;
         lock_cmd_enabled_flag_r <= 1'b1;
         pe_ack_r                <= 1'b0;
         pe_allow_r              <= 1'b0;
      end else begin
         for (int i = 0; i < NB; i++) begin
            prot_r[i]  <= prot_nxt[i];
            lock_r[i]  <= lock_nxt[i];
            stage_r[i] <= stage_nxt[i];
         end
         frozen_r                <= frozen_nxt;
         nvop_r                  <= nvop_nxt;
         timer_r                 <= timer_nxt;
         addr_r                  <= addr_nxt;
         busy_r                  <= (nvop_nxt != spl_pkg::SPL_NV_NONE);
         lock_cmd_enabled_flag_r <= !frozen_nxt;
         pe_ack_r                <= pe_ack_nxt;
         pe_allow_r              <= pe_allow_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: test/spl_core_assertions.sv */
// port-level checks for the sector protection and lockdown block
`default_nettype none
module spl_core_assertions #(
   parameter int unsigned PROG_CYC = 20,
   parameter int unsigned FRZ_CYC  = 20
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // spi pins
   input wire logic        sck,
   input wire logic        cs_n,
   input wire logic        si,
   input wire logic        so,
   input wire logic        so_oe,
   // status
   input wire logic        busy_r,
   input wire logic        lock_cmd_enabled_flag_r,
   // buffer 1 write port
   input wire logic        buf1_we_r,
   input wire logic [2:0]  buf1_idx_r,
   input wire logic [7:0]  buf1_data_r,
   // permission query
   input wire logic        pe_req,
   input wire logic [18:0] pe_addr,
   input wire logic        prot_en,
   input wire logic        pe_ack_r,
   input wire logic        pe_allow_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] busy_cnt_r;
   logic [31:0] busy_cnt_nxt;
   ////////////////////////////////////////////////////////////////////////
   // length of the current busy span
   always_comb busy_cnt_nxt = busy_r ? busy_cnt_r + 32'h1 : 32'h0;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) busy_cnt_r <= 32'h0;
      else busy_cnt_r <= busy_cnt_nxt;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_so_float_cs: assert property ($rose(cs_n) |-> ##5 !so_oe)
      else $error("serial output still driven after chip select rise");
   a_busy_after_cs: assert property ($rose(busy_r) |->
      cs_n && $past(cs_n, 3))
      else $error("busy rose without chip select rise");
   a_busy_span_len: assert property ($fell(busy_r) |->
      busy_cnt_r == PROG_CYC || busy_cnt_r == FRZ_CYC)
      else $error("busy span length wrong");
   a_busy_no_traffic: assert property (busy_r |-> !so_oe && !buf1_we_r)
      else $error("output or buffer write while busy");
   a_query_ack_next: assert property (pe_ack_r == $past(pe_req))
      else $error("query acknowledge not one cycle after request");
   a_buf_we_pulse: assert property (buf1_we_r |=> !buf1_we_r)
      else $error("buffer write longer than one cycle");
   a_buf_we_frame: assert property (buf1_we_r |-> !cs_n)
      else $error("buffer write outside a frame");
   a_flag_stays_low: assert property (!lock_cmd_enabled_flag_r
      |=> !lock_cmd_enabled_flag_r)
      else $error("lock enable flag came back");
   a_flag_at_end: assert property ($fell(lock_cmd_enabled_flag_r)
      |-> $fell(busy_r))
      else $error("lock enable flag cleared outside freeze end");
   a_so_moves_oe: assert property ($changed(so) |-> so_oe)
      else $error("serial output changed while not driven");
   a_allow_steady: assert property (!$past(rst) && $stable(pe_addr) &&
      $stable(prot_en) && $stable(busy_r) |=> $stable(pe_allow_r))
      else $error("permission answer changed with no cause");
   c_busy: cover property ($rose(busy_r));
   c_read_out: cover property ($rose(so_oe));
   c_frozen: cover property ($fell(lock_cmd_enabled_flag_r));
   c_buf_write: cover property (buf1_we_r && buf1_idx_r == 3'h7);
endmodule
`default_nettype wire

/* File: test/spl_host.sv */
// spi host model driving the flash command pins
`default_nettype none
module spl_host (
   // clock
   input wire logic core_clk,
   // spi pins
   output var logic sck,
   output var logic cs_n,
   output var logic si,
   input wire logic so,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // frame edge; rise ends reads and starts timed work
   task automatic cs_set(input logic v);
      repeat (10) @(posedge core_clk);
      cs_n <= v;
      if (v) si <= ~si;
      repeat (10) @(posedge core_clk);
   endtask
   // one byte, msb first, mode 0, 160 ns period
   task automatic xfer(input  logic [7:0] tx,
                       output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si <= tx[i];
         repeat (10) @(posedge core_clk);
         sck <= 1'b1;
         rx[i] = so_oe ? so : 1'bz;
         repeat (10) @(posedge core_clk);
         sck <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* File: test/tb_spl_core.sv */
// self-checking bench for the sector protection and lockdown block
`default_nettype none
module tb_spl_core;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [18:0] addr;
      logic        prot;
      logic        allow;
   } spl_row_t;
   logic        core_clk;
   logic        rst;
   logic        sck;
   logic        cs_n;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        busy_r;
   logic        flag;
   logic        buf1_we_r;
   logic [2:0]  buf1_idx_r;
   logic [7:0]  buf1_data_r;
   logic        pe_req;
   logic [18:0] pe_addr;
   logic        prot_en;
   logic        pe_ack_r;
   logic        pe_allow_r;
   logic [10:0] wq [$];
   logic [7:0]  txq [$];
   logic [7:0]  pd [$] = '{8'hf3, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff,
                          8'h00, 8'h00, 8'hc5};
   spl_row_t    rows [10] = '{'{19'h00000, 1'b1, 1'b0},
      '{19'h00000, 1'b0, 1'b1}, '{19'h00800, 1'b0, 1'b0},
      '{19'h00800, 1'b1, 1'b0}, '{19'h10000, 1'b1, 1'b0},
      '{19'h10000, 1'b0, 1'b1}, '{19'h30000, 1'b0, 1'b0},
      '{19'h20000, 1'b1, 1'b1}, '{19'h50000, 1'b1, 1'b0},
      '{19'h70000, 1'b1, 1'b1}};
   int          error_cnt = 0;
   int          cmp_count = 0;
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   spl_core #(.PROG_CYC(20), .FRZ_CYC(24)) uut (
      .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
      .so(so), .so_oe(so_oe), .busy_r(busy_r),
      .lock_cmd_enabled_flag_r(flag), .buf1_we_r(buf1_we_r),
      .buf1_idx_r(buf1_idx_r), .buf1_data_r(buf1_data_r),
      .pe_req(pe_req), .pe_addr(pe_addr), .prot_en(prot_en),
      .pe_ack_r(pe_ack_r), .pe_allow_r(pe_allow_r));
   spl_host host (.core_clk(core_clk), .sck(sck), .cs_n(cs_n), .si(si),
      .so(so), .so_oe(so_oe));
   always @(posedge core_clk) begin
      if (buf1_we_r === 1'b1) wq.push_back({buf1_idx_r, buf1_data_r});
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [63:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic frame(input logic [7:0] tx [$]);
      logic [7:0] rx;
      host.cs_set(1'b0);
      foreach (tx[i]) host.xfer(tx[i], rx);
      host.cs_set(1'b1);
   endtask
   task automatic read_map(input logic [7:0] op, input logic [63:0] exp);
      logic [7:0] rx;
      host.cs_set(1'b0);
      host.xfer(op, rx);
      repeat (3) host.xfer(8'h00, rx);
      for (int k = 0; k < 8; k++) begin
         host.xfer(8'h00, rx);
         chk("map byte", 64'(rx), 64'(exp[63-8*k -: 8]));
      end
      host.cs_set(1'b1);
      chk("so_oe idle", 64'(so_oe), 64'h0);
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (busy_r !== 1'b0 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      chk("ready", 64'(busy_r), 64'h0);
   endtask
   task automatic query(input spl_row_t r);
      @(posedge core_clk);
      pe_addr <= r.addr;
      prot_en <= r.prot;
      pe_req <= 1'b1;
      @(posedge core_clk);
      pe_req <= 1'b0;
      #1;
      chk("pe_ack", 64'(pe_ack_r), 64'h1);
      chk("pe_allow", 64'(pe_allow_r), 64'(r.allow));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      $display("ERROR watchdog expected done seen timeout");
      test_done();
   end
   initial begin
      rst = 1'b1;
      pe_req = 1'b0;
      pe_addr = 19'h0;
      prot_en = 1'b0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("busy reset", 64'(busy_r), 64'h0);
      chk("flag reset", 64'(flag), 64'h1);
      read_map(8'h32, 64'h0);
      read_map(8'h35, 64'h0);
      // nine data bytes with protection on: last wraps to byte 0
      prot_en <= 1'b1;
      txq = '{8'h3d, 8'h2a, 8'h7f, 8'hfc};
      foreach (pd[i]) txq.push_back(pd[i]);
      frame(txq);
      chk("busy prog", 64'(busy_r), 64'h1);
      wait_ready();
      chk("buf1 count", 64'(wq.size()), 64'h9);
      for (int k = 0; k < 9; k++) begin
         chk("buf1 write", 64'(wq[k]), 64'({k[2:0], pd[k]}));
      end
      read_map(8'h32, 64'hc5ff00ff00ff0000);
      frame('{8'h3d, 8'h2a, 8'h7f, 8'h30, 8'h03, 8'h12, 8'h34});
      chk("busy lock", 64'(busy_r), 64'h1);
      wait_ready();
      frame('{8'h3d, 8'h2a, 8'h7f, 8'h30, 8'h00, 8'h08, 8'h00});
      wait_ready();
      read_map(8'h35, 64'h300000ff00000000);
      frame('{8'h3d, 8'h2a});
      chk("busy short", 64'(busy_r), 64'h0);
      foreach (rows[i]) query(rows[i]);
      frame('{8'h34, 8'h55, 8'haa, 8'h40, 8'h3d});
      chk("busy freeze", 64'(busy_r), 64'h1);
      wait_ready();
      chk("flag frozen", 64'(flag), 64'h0);
      frame('{8'h3d, 8'h2a, 8'h7f, 8'h30, 8'h07, 8'h00, 8'h00});
      chk("busy frozen", 64'(busy_r), 64'h0);
      query('{19'h70000, 1'b0, 1'b1});
      read_map(8'h35, 64'h300000ff00000000);
      test_done();
   end
endmodule
bind spl_core spl_core_assertions #(.PROG_CYC(PROG_CYC), .FRZ_CYC(FRZ_CYC))
   chk_i (.core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n),
   .si(si), .so(so), .so_oe(so_oe), .busy_r(busy_r),
   .lock_cmd_enabled_flag_r(lock_cmd_enabled_flag_r),
   .buf1_we_r(buf1_we_r), .buf1_idx_r(buf1_idx_r),
   .buf1_data_r(buf1_data_r), .pe_req(pe_req), .pe_addr(pe_addr),
   .prot_en(prot_en), .pe_ack_r(pe_ack_r), .pe_allow_r(pe_allow_r));
`default_nettype wire
